// [pkg/dma_pkg.sv]
// Shared constants, port map and state types for the DMA channel logic and serial link
package dma_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 2;
  localparam int REQ_BITS = 8;
  localparam int GNT_BITS = 3;
  localparam logic [7:0] CH_USABLE = 8'hef;
  // Register word indices; the bus byte address is four times the index
  localparam logic [7:0] PORT_CMD0 = 8'h08;
  localparam logic [7:0] PORT_REQ0 = 8'h09;
  localparam logic [7:0] PORT_MASK0 = 8'h0a;
  localparam logic [7:0] PORT_MODE0 = 8'h0b;
  localparam logic [7:0] PORT_CLR_PTR0 = 8'h0c;
  localparam logic [7:0] PORT_MCLR0 = 8'h0d;
  localparam logic [7:0] PORT_CLR_MASK0 = 8'h0e;
  localparam logic [7:0] PORT_CMD1 = 8'hd0;
  localparam logic [7:0] PORT_REQ1 = 8'hd2;
  localparam logic [7:0] PORT_MASK1 = 8'hd4;
  localparam logic [7:0] PORT_MODE1 = 8'hd6;
  localparam logic [7:0] PORT_CLR_PTR1 = 8'hd8;
  localparam logic [7:0] PORT_MCLR1 = 8'hda;
  localparam logic [7:0] PORT_CLR_MASK1 = 8'hdc;
  localparam logic [3:0] CHREG1_NIBBLE = 4'hc;
  localparam logic [7:0] PORT_STYLE = 8'h90;
  localparam logic [7:0] PORT_PEND_A = 8'h92;
  localparam logic [7:0] PORT_PEND_B = 8'h93;
  localparam logic [7:0] PAGE_PORT [NUM_CH] = '{8'h87, 8'h83, 8'h81, 8'h82,
                                                8'h8f, 8'h8b, 8'h89, 8'h8a};
  // Field positions and codes
  localparam int MODE_TYPE_LSB = 2;
  localparam int MODE_AUTO_BIT = 4;
  localparam int MODE_DEC_BIT = 5;
  localparam int SET_BIT = 2;
  localparam int CMD_DIS_BIT = 2;
  localparam logic [1:0] STYLE_LPC = 2'h0;
  localparam logic [1:0] STYLE_PAIR_A = 2'h1;
  localparam logic [1:0] STYLE_PAIR_B = 2'h2;
  localparam logic [15:0] STYLE_WMASK = 16'hfcff;
  localparam logic [1:0] XFER_TO_MEM = 2'h1;
  localparam logic [1:0] XFER_FROM_MEM = 2'h2;
  // Reset values and link gaps
  localparam logic [15:0] STYLE_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [1:0] GAP_NEW = 2'h1;
  localparam logic [1:0] GAP_DONE = 2'h2;

  typedef enum logic [2:0] {
    X_IDLE = 3'b000, X_GNT = 3'b001, X_RD = 3'b010, X_WR = 3'b011, X_STEP = 3'b100
  } xfer_state_e;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_GAP = 2'b01, R_BITS = 2'b10
  } req_state_e;
  typedef enum logic [1:0] {
    G_IDLE = 2'b00, G_BITS = 2'b01, G_HOLD = 2'b10
  } gnt_state_e;
endpackage : dma_pkg

// [pkg/dma_serial_if.sv]
// One serial request/grant pair between the DMA controller and an expansion agent
`timescale 1ns/1ns
interface dma_serial_if;
  logic req_n;
  logic gnt_n;
  modport device (input req_n, output gnt_n);
  modport agent (output req_n, input gnt_n);
endinterface : dma_serial_if

// [core/dma_channel.sv]
// One DMA channel: base and current address, count and page, stepping and address shift
`timescale 1ns/1ns
module dma_channel #(
  parameter bit WIDE = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Processor load
  input wire logic ld_i,
  input wire logic ld_page_i,
  input wire logic ld_cnt_i,
  input wire logic ld_hi_i,
  input wire logic [7:0] ld_data_i,
  // Transfer stepping
  input wire logic step_i,
  input wire logic dec_i,
  input wire logic auto_i,
  // State
  output logic [15:0] cur_addr_o,
  output logic [15:0] cur_cnt_o,
  output logic [7:0] page_o,
  output logic tc_o,
  output logic [23:0] mem_addr_o
);
  logic [15:0] base_addr;
  logic [15:0] base_cnt;
  logic [7:0] base_page;
  logic [3:0] lane;

  assign lane = {ld_hi_i, 3'h0};
  assign tc_o = (cur_cnt_o == 16'h0000);
  // Page bit 0 is dropped on word channels; the page never takes a carry
  assign mem_addr_o = WIDE ? {page_o[7:1], cur_addr_o, 1'b0} : {page_o, cur_addr_o};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_addr <= 16'h0000;
      base_cnt <= 16'h0000;
      base_page <= 8'h00;
      cur_addr_o <= 16'h0000;
      cur_cnt_o <= 16'h0000;
      page_o <= 8'h00;
    end else if (ld_i) begin
      if (ld_page_i) begin
        base_page <= ld_data_i;
        page_o <= ld_data_i;
      end else if (ld_cnt_i) begin
        base_cnt[lane +: 8] <= ld_data_i;
        cur_cnt_o[lane +: 8] <= ld_data_i;
      end else begin
        base_addr[lane +: 8] <= ld_data_i;
        cur_addr_o[lane +: 8] <= ld_data_i;
      end
    end else if (step_i) begin
      if (tc_o && auto_i) begin
        cur_addr_o <= base_addr;
        cur_cnt_o <= base_cnt;
        page_o <= base_page;
      end else begin
        cur_addr_o <= dec_i ? cur_addr_o - 16'h0001 : cur_addr_o + 16'h0001;
        cur_cnt_o <= cur_cnt_o - 16'h0001;
      end
    end
  end
endmodule : dma_channel

// [core/dma_device.sv]
// DMA controller end: channel registers, software commands, routing and serial link
// How it works
// - Address steps by one; count bytes or words
// - Mode bit picks address up or down
// - Word channels shift address, drop page bit
// - Autoinit reloads current registers at terminal count
// - Processor write loads base and current together
// - Autoinit terminal count leaves mask bit clear
// - Command ports act on write, data ignored
// - Two byte pointers, each with clear port
// - Byte pointer alternates low and high byte
// - Master clear resets group, sets its four masks
// - Clear-mask port unmasks its four channels
// - Serial channel runs read then write cycle
// - Two independent request/grant pairs provided
// - Style register routes each channel except 4 independently
// - Serial request: one clock per channel
// - Grant: start bit, three bits LSB first
// - Agent resends after transfer, two-clock gap
// - Withdrawn request: one-clock gap, then resend
// - New request: one-clock gap, then resend
// - Agent request and grant machines run independently
// - Withdrawn request needs no device handling
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module dma_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial request/grant pairs
  dma_serial_if.device link_a,
  dma_serial_if.device link_b,
  // Requests from channels routed to LPC
  input wire logic [7:0] lpc_req_i,
  // Transfer cycles
  output logic cyc_o,
  output logic cyc_we_o,
  output logic cyc_mem_o,
  output logic [23:0] cyc_addr_o,
  output logic [2:0] cyc_ch_o,
  output logic cyc_tc_o,
  input wire logic cyc_ack_i
);
  localparam int NC = dma_pkg::NUM_CH;
  localparam int NP = dma_pkg::NUM_PAIR;

  logic [15:0] style;
  logic [7:0] mask;
  logic [7:0] mode_dec;
  logic [7:0] mode_auto;
  logic [1:0] mode_type [NC];
  logic [7:0] cmd0;
  logic [7:0] cmd1;
  logic [7:0] sw_req;
  logic [7:0] tc_stat;
  logic [1:0] ptr;
  logic [7:0] pend [NP];
  logic [NP-1:0] req_in;
  logic [NP-1:0] gnt_q;

  logic [15:0] cur_addr [NC];
  logic [15:0] cur_cnt [NC];
  logic [7:0] page [NC];
  logic [23:0] mem_addr [NC];
  logic [7:0] tc_now;
  logic [7:0] step_vec;

  logic [7:0] idx;
  logic acc;
  logic wr8;
  logic cp_hit;
  logic cp_cnt;
  logic [2:0] cp_ch;
  logic pg_hit;
  logic [2:0] pg_ch;
  logic [7:0] d;
  logic [31:0] rd;
  logic [15:0] word;
  logic [7:0] eff_req;
  logic [7:0] avail;
  logic [7:0] grp_off;
  logic [2:0] pick;
  logic mclr_cur;

  dma_pkg::xfer_state_e state;
  logic [2:0] cur_ch;
  logic cur_pair;
  logic cur_serial;
  logic [1:0] gcnt;

  assign idx = adr_i;
  assign d = dat_i[7:0];
  // Actions happen on the edge where the master samples ack
  assign acc = cyc_i && stb_i && ack_o;
  assign wr8 = acc && we_i && sel_i[0];
  assign req_in = {link_b.req_n, link_a.req_n};
  assign link_a.gnt_n = gnt_q[0];
  assign link_b.gnt_n = gnt_q[1];

  generate
    for (genvar c = 0; c < NC; c++) begin : g_ch
      dma_channel #(.WIDE(c >= 4)) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ld_i(wr8 && ((cp_hit && cp_ch == 3'(c)) || (pg_hit && pg_ch == 3'(c)))),
        .ld_page_i(pg_hit),
        .ld_cnt_i(cp_cnt),
        .ld_hi_i(ptr[c / 4]),
        .ld_data_i(d),
        .step_i(step_vec[c]),
        .dec_i(mode_dec[c]),
        .auto_i(mode_auto[c]),
        .cur_addr_o(cur_addr[c]),
        .cur_cnt_o(cur_cnt[c]),
        .page_o(page[c]),
        .tc_o(tc_now[c]),
        .mem_addr_o(mem_addr[c])
      );
    end
  endgenerate

  // Address decode
  always_comb begin
    cp_hit = 1'b0;
    cp_ch = 3'h0;
    cp_cnt = 1'b0;
    pg_hit = 1'b0;
    pg_ch = 3'h0;
    if (idx[7:3] == 5'h00) begin
      cp_hit = 1'b1;
      cp_ch = {1'b0, idx[2:1]};
      cp_cnt = idx[0];
    end else if (idx[7:4] == dma_pkg::CHREG1_NIBBLE && !idx[0]) begin
      cp_hit = 1'b1;
      cp_ch = {1'b1, idx[3:2]};
      cp_cnt = idx[1];
    end
    for (int c = 0; c < NC; c++) begin
      if (idx == dma_pkg::PAGE_PORT[c]) begin
        pg_hit = 1'b1;
        pg_ch = 3'(c);
      end
    end
  end

  // Read data
  always_comb begin
    word = cp_cnt ? cur_cnt[cp_ch] : cur_addr[cp_ch];
    rd = 32'h0000_0000;
    if (cp_hit) begin
      rd[7:0] = ptr[cp_ch[2]] ? word[15:8] : word[7:0];
    end else if (pg_hit) begin
      rd[7:0] = page[pg_ch];
    end else begin
      case (idx)
        dma_pkg::PORT_CMD0: rd[7:0] = {eff_req[3:0], tc_stat[3:0]};
        dma_pkg::PORT_CMD1: rd[7:0] = {eff_req[7:4], tc_stat[7:4]};
        dma_pkg::PORT_STYLE: rd[15:0] = style;
        dma_pkg::PORT_PEND_A: rd[7:0] = pend[0];
        dma_pkg::PORT_PEND_B: rd[7:0] = pend[1];
        default: rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= rd;
    end
  end

  // Routing and request selection
  always_comb begin
    eff_req = 8'h00;
    for (int c = 0; c < NC; c++) begin
      case (style[2 * c +: 2])
        dma_pkg::STYLE_PAIR_A: eff_req[c] = pend[0][c];
        dma_pkg::STYLE_PAIR_B: eff_req[c] = pend[1][c];
        default: eff_req[c] = lpc_req_i[c];
      endcase
    end
    eff_req = eff_req | sw_req;
    grp_off = {{4{cmd1[dma_pkg::CMD_DIS_BIT]}}, {4{cmd0[dma_pkg::CMD_DIS_BIT]}}};
    avail = eff_req & ~mask & ~grp_off & dma_pkg::CH_USABLE;
    pick = 3'h0;
    for (int c = NC - 1; c >= 0; c--) begin
      if (avail[c]) begin
        pick = 3'(c);
      end
    end
  end

  // Serial request decoders, one per pair; a resend simply replaces the old pattern
  generate
    for (genvar p = 0; p < NP; p++) begin : g_rx
      logic busy;
      logic [2:0] cnt;
      logic [6:0] shift;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          busy <= 1'b0;
          cnt <= 3'h0;
          shift <= 7'h00;
          pend[p] <= 8'h00;
        end else if (!busy) begin
          busy <= !req_in[p];
          cnt <= 3'h0;
        end else if (cnt == 3'(dma_pkg::REQ_BITS - 1)) begin
          pend[p] <= {req_in[p], shift};
          busy <= 1'b0;
        end else begin
          shift[cnt] <= req_in[p];
          cnt <= cnt + 3'h1;
        end
        // A served channel is forgotten until the agent resends its pattern
        if (!rst_i && state == dma_pkg::X_STEP && cur_serial && cur_pair == 1'(p)) begin
          pend[p][cur_ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // Software-visible registers and commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      style <= dma_pkg::STYLE_RESET;
      mask <= dma_pkg::MASK_RESET;
      mode_dec <= 8'h00;
      mode_auto <= 8'h00;
      mode_type <= '{default: 2'h0};
      cmd0 <= 8'h00;
      cmd1 <= 8'h00;
      sw_req <= 8'h00;
      tc_stat <= 8'h00;
      ptr <= 2'h0;
    end else begin
      if (acc && cp_hit) begin
        ptr[cp_ch[2]] <= !ptr[cp_ch[2]];
      end
      if (acc && we_i && idx == dma_pkg::PORT_STYLE) begin
        if (sel_i[0]) style[7:0] <= d & dma_pkg::STYLE_WMASK[7:0];
        if (sel_i[1]) style[15:8] <= dat_i[15:8] & dma_pkg::STYLE_WMASK[15:8];
      end
      // Reading status clears the terminal-count bits of that group
      if (acc && !we_i && idx == dma_pkg::PORT_CMD0) tc_stat[3:0] <= 4'h0;
      if (acc && !we_i && idx == dma_pkg::PORT_CMD1) tc_stat[7:4] <= 4'h0;
      if (wr8) begin
        case (idx)
          dma_pkg::PORT_CMD0: cmd0 <= d;
          dma_pkg::PORT_CMD1: cmd1 <= d;
          dma_pkg::PORT_REQ0, dma_pkg::PORT_REQ1: begin
            sw_req[{idx[7], d[1:0]}] <= d[dma_pkg::SET_BIT];
          end
          dma_pkg::PORT_MASK0, dma_pkg::PORT_MASK1: begin
            mask[{idx[7], d[1:0]}] <= d[dma_pkg::SET_BIT];
          end
          dma_pkg::PORT_MODE0, dma_pkg::PORT_MODE1: begin
            mode_type[{idx[7], d[1:0]}] <= d[dma_pkg::MODE_TYPE_LSB +: 2];
            mode_auto[{idx[7], d[1:0]}] <= d[dma_pkg::MODE_AUTO_BIT];
            mode_dec[{idx[7], d[1:0]}] <= d[dma_pkg::MODE_DEC_BIT];
          end
          dma_pkg::PORT_CLR_PTR0: ptr[0] <= 1'b0;
          dma_pkg::PORT_CLR_PTR1: ptr[1] <= 1'b0;
          dma_pkg::PORT_CLR_MASK0: mask[3:0] <= 4'h0;
          dma_pkg::PORT_CLR_MASK1: mask[7:4] <= 4'h0;
          dma_pkg::PORT_MCLR0, dma_pkg::PORT_MCLR1: begin
            ptr[idx[7]] <= 1'b0;
            if (idx[7]) cmd1 <= 8'h00;
            else cmd0 <= 8'h00;
            for (int c = 0; c < NC; c++) begin
              if ((c / 4) == int'(idx[7])) begin
                mask[c] <= 1'b1;
                sw_req[c] <= 1'b0;
                tc_stat[c] <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
      // Placed last so a terminal count wins over a same-cycle clear
      if (state == dma_pkg::X_STEP && tc_now[cur_ch]) begin
        tc_stat[cur_ch] <= 1'b1;
        sw_req[cur_ch] <= 1'b0;
        if (!mode_auto[cur_ch]) mask[cur_ch] <= 1'b1;
      end
    end
  end

  assign mclr_cur = wr8 && (idx == dma_pkg::PORT_MCLR0 || idx == dma_pkg::PORT_MCLR1)
                    && (cur_ch[2] == idx[7]);

  // Service sequence: grant on the serial pair (skipped for LPC channels), source read, destination write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= dma_pkg::X_IDLE;
      cur_ch <= 3'h0;
      cur_pair <= 1'b0;
      cur_serial <= 1'b0;
      gcnt <= 2'h0;
      gnt_q <= {NP{1'b1}};
    end else if (mclr_cur) begin
      state <= dma_pkg::X_IDLE;
      gnt_q <= {NP{1'b1}};
    end else begin
      case (state)
        dma_pkg::X_IDLE: begin
          gnt_q <= {NP{1'b1}};
          if (|avail) begin
            cur_ch <= pick;
            cur_pair <= (style[2 * pick +: 2] == dma_pkg::STYLE_PAIR_B);
            cur_serial <= (style[2 * pick +: 2] == dma_pkg::STYLE_PAIR_A) ||
                          (style[2 * pick +: 2] == dma_pkg::STYLE_PAIR_B);
            gcnt <= 2'h0;
            if (style[2 * pick +: 2] == dma_pkg::STYLE_PAIR_A ||
                style[2 * pick +: 2] == dma_pkg::STYLE_PAIR_B) begin
              state <= dma_pkg::X_GNT;
            end else begin
              state <= dma_pkg::X_RD;
            end
          end
        end
        dma_pkg::X_GNT: begin
          if (gcnt == 2'h0) begin
            gnt_q[cur_pair] <= 1'b0;
            gcnt <= 2'h1;
          end else begin
            gnt_q[cur_pair] <= cur_ch[gcnt - 2'h1];
            gcnt <= gcnt + 2'h1;
            if (gcnt == 2'(dma_pkg::GNT_BITS)) state <= dma_pkg::X_RD;
          end
        end
        dma_pkg::X_RD: begin
          // LPC service must leave both grant lines idle
          if (cur_serial) gnt_q[cur_pair] <= 1'b0;
          if (cyc_ack_i) state <= dma_pkg::X_WR;
        end
        dma_pkg::X_WR: begin
          if (cyc_ack_i) state <= dma_pkg::X_STEP;
        end
        dma_pkg::X_STEP: begin
          gnt_q <= {NP{1'b1}};
          state <= dma_pkg::X_IDLE;
        end
        default: state <= dma_pkg::X_IDLE;
      endcase
    end
  end

  always_comb begin
    step_vec = 8'h00;
    step_vec[cur_ch] = (state == dma_pkg::X_STEP);
  end

  assign cyc_o = (state == dma_pkg::X_RD) || (state == dma_pkg::X_WR);
  assign cyc_we_o = (state == dma_pkg::X_WR);
  assign cyc_mem_o = (state == dma_pkg::X_RD) == (mode_type[cur_ch] == dma_pkg::XFER_FROM_MEM);
  assign cyc_addr_o = mem_addr[cur_ch];
  assign cyc_ch_o = cur_ch;
  assign cyc_tc_o = tc_now[cur_ch];
endmodule : dma_device

// [core/dma_agent.sv]
// Expansion agent end: serial request sender and grant receiver running side by side
`timescale 1ns/1ns
module dma_agent #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  dma_serial_if.agent link,
  // Local channel request and acknowledge lines
  input wire logic [7:0] channel_request_line_i,
  output logic [7:0] channel_acknowledge_line_o
);
  if (CHANNELS != dma_pkg::REQ_BITS) begin : g_bad
    $error("dma_agent: CHANNELS must be 8");
  end

  dma_pkg::req_state_e rstate;
  dma_pkg::gnt_state_e gstate;
  logic req_q;
  logic [7:0] sent;
  logic [7:0] shot;
  logic [2:0] rcnt;
  logic [1:0] gap;
  logic redo;
  logic done;
  logic [1:0] gcnt;
  logic [2:0] gch;

  assign link.req_n = req_q;

  // Request sender
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstate <= dma_pkg::R_IDLE;
      req_q <= 1'b1;
      sent <= 8'h00;
      shot <= 8'h00;
      rcnt <= 3'h0;
      gap <= 2'h0;
      redo <= 1'b0;
    end else begin
      case (rstate)
        dma_pkg::R_IDLE: begin
          req_q <= 1'b1;
          if (redo || channel_request_line_i != sent) begin
            gap <= (redo ? dma_pkg::GAP_DONE : dma_pkg::GAP_NEW) - 2'h1;
            rstate <= dma_pkg::R_GAP;
          end
        end
        dma_pkg::R_GAP: begin
          if (gap == 2'h0) begin
            req_q <= 1'b0;
            shot <= channel_request_line_i;
            redo <= 1'b0;
            rcnt <= 3'h0;
            rstate <= dma_pkg::R_BITS;
          end else begin
            req_q <= 1'b1;
            gap <= gap - 2'h1;
          end
        end
        dma_pkg::R_BITS: begin
          req_q <= shot[rcnt];
          rcnt <= rcnt + 3'h1;
          if (rcnt == 3'(dma_pkg::REQ_BITS - 1)) begin
            sent <= shot;
            rstate <= dma_pkg::R_IDLE;
          end
        end
        default: rstate <= dma_pkg::R_IDLE;
      endcase
      // A finished transfer forces a full resend; set wins over the clear above
      if (done) redo <= 1'b1;
    end
  end

  // Grant receiver, independent of the sender
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gstate <= dma_pkg::G_IDLE;
      gcnt <= 2'h0;
      gch <= 3'h0;
      done <= 1'b0;
      channel_acknowledge_line_o <= 8'h00;
    end else begin
      done <= 1'b0;
      case (gstate)
        dma_pkg::G_IDLE: begin
          gcnt <= 2'h0;
          if (!link.gnt_n) gstate <= dma_pkg::G_BITS;
        end
        dma_pkg::G_BITS: begin
          gch[gcnt] <= link.gnt_n;
          gcnt <= gcnt + 2'h1;
          if (gcnt == 2'(dma_pkg::GNT_BITS - 1)) gstate <= dma_pkg::G_HOLD;
        end
        dma_pkg::G_HOLD: begin
          if (link.gnt_n) begin
            channel_acknowledge_line_o <= 8'h00;
            done <= 1'b1;
            gstate <= dma_pkg::G_IDLE;
          end else begin
            channel_acknowledge_line_o <= 8'h01 << gch;
          end
        end
        default: gstate <= dma_pkg::G_IDLE;
      endcase
    end
  end
endmodule : dma_agent

// [verif/dma_link_properties.sv]
// Assertions on one serial request/grant pair
`timescale 1ns/1ns
module dma_link_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial pair
  input wire logic req_n,
  input wire logic gnt_n
);
  logic [2:0] g;
  logic [3:0] r;
  logic [2:0] gch;
  logic [7:0] pat;
  logic [7:0] last;
  logic [7:0] prev;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Grant frame: 1..3 channel bits, 4 hold
  always_ff @(posedge clk_i) begin
    if (rst_i) g <= 3'h0;
    else if (g == 3'h0) g <= {2'h0, ~gnt_n};
    else if (g != 3'h4) g <= g + 3'h1;
    else if (gnt_n) g <= 3'h0;
  end
  always_ff @(posedge clk_i) begin
    if (g != 3'h0 && g != 3'h4) gch[g - 3'h1] <= gnt_n;
  end
  // Request frame: 1..8 channel bits, 9 gap
  always_ff @(posedge clk_i) begin
    if (rst_i) r <= 4'h0;
    else if (r == 4'h0) r <= {3'h0, ~req_n};
    else if (r == 4'h9) r <= 4'h0;
    else r <= r + 4'h1;
  end
  // Two patterns kept: a grant may be chosen just before a new one lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= 8'h0;
      prev <= 8'h0;
    end else if (r == 4'h9) begin
      last <= pat;
      prev <= last;
    end
    if (r != 4'h0 && r != 4'h9) pat[r - 4'h1] <= req_n;
  end
  a_idle_after_reset:
    assert property ($fell(rst_i) |-> req_n && gnt_n) else $error("lines not idle");
  a_req_gap_high:
    assert property (r == 4'h9 |-> req_n) else $error("no gap after pattern");
  a_gnt_hold_low:
    assert property (g == 3'h4 && $past(g) == 3'h3 |-> !gnt_n) else $error("grant not held");
  a_gnt_usable_ch:
    assert property (g == 3'h4 && $past(g) == 3'h3 |-> dma_pkg::CH_USABLE[gch])
    else $error("grant to unusable channel");
  a_gnt_requested:
    assert property (g == 3'h4 && $past(g) == 3'h3 |-> |((last | prev) & (8'h01 << gch)))
    else $error("grant to channel not requested");
  a_service_ends:
    assert property (g == 3'h4 && $past(g) == 3'h3 |-> ##[1:300] gnt_n)
    else $error("service never ends");
  a_pend_before_gnt:
    assert property ($fell(gnt_n) && g == 3'h0 |-> (last | prev) != 8'h0)
    else $error("grant without request");
  a_resend_after_gnt:
    assert property ($rose(gnt_n) && g == 3'h4 |-> ##[1:30] $fell(req_n))
    else $error("no resend after grant");
  c_grant: cover property (g == 3'h4 && $past(g) == 3'h3);
  c_frame: cover property (r == 4'h9);
  c_grant_end: cover property ($rose(gnt_n) && g == 3'h4);
  c_gnt_mid_frame: cover property (g != 3'h0 && r != 4'h0);
endmodule : dma_link_properties

// [verif/tb.sv]
// Bench for the DMA controller with two serial agents
`timescale 1ns/1ns
module tb;
  logic clk_i, rst_i, cyc, stb, we, ack, cyc_o, cyc_mem, cyc_ack, hi, cyc_we, cyc_tc, seen_we, seen_tc;
  logic [2:0] cyc_ch, seen_ch;
  logic [3:0] sel;
  logic [7:0] adr, req_a, req_b, ack_a, ack_b, lpc_req, seen_ack;
  logic [31:0] dat, rd, rdv, v;
  logic [23:0] cyc_addr, seen_mem;
  logic [15:0] got;
  int mismatches, n_compared, cycles, i, k;
  integer seed;
  dma_serial_if la ();
  dma_serial_if lb ();
  dma_device dma_device_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack),
    .link_a(la.device), .link_b(lb.device), .lpc_req_i(lpc_req), .cyc_o(cyc_o),
    .cyc_we_o(cyc_we), .cyc_mem_o(cyc_mem), .cyc_addr_o(cyc_addr), .cyc_ch_o(cyc_ch),
    .cyc_tc_o(cyc_tc), .cyc_ack_i(cyc_ack));
  dma_agent dma_agent_i (.clk_i(clk_i), .rst_i(rst_i), .link(la.agent),
    .channel_request_line_i(req_a), .channel_acknowledge_line_o(ack_a));
  dma_agent dma_agent_b_i (.clk_i(clk_i), .rst_i(rst_i), .link(lb.agent),
    .channel_request_line_i(req_b), .channel_acknowledge_line_o(ack_b));
  dma_link_properties dma_link_properties_i (.clk_i(clk_i), .rst_i(rst_i),
    .req_n(la.req_n), .gnt_n(la.gnt_n));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Far side of the transfer cycles answers every phase after one cycle
  always @(posedge clk_i) begin
    cyc_ack <= cyc_o && !cyc_ack;
    cycles++;
    if (cyc_o && cyc_mem) begin
      seen_mem <= cyc_addr;
      seen_we <= cyc_we;
    end
    if (cyc_o) begin
      seen_ch <= cyc_ch;
      seen_tc <= cyc_tc;
    end
    if ((ack_a | ack_b) != 8'h0) seen_ack <= ack_a | ack_b;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  // Address after one transfer; the 16-bit result wraps like the hardware
  function automatic logic [15:0] exp_addr(input int n, input logic [15:0] a);
    if (n == 3) return a;
    return n[1] ? a - 16'h1 : a + 16'h1;
  endfunction : exp_addr
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdv = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, {24'h0, d[7:0]});
    wb(1'b1, a, {24'h0, d[15:8]});
  endtask : wr16
  task automatic rd16(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
    got[7:0] = rdv[7:0];
    wb(1'b0, a, 32'h0);
    got[15:8] = rdv[7:0];
  endtask : rd16
  task automatic wait_grant();
    for (k = 0; k < 300 && seen_ack === 8'h0; k++) @(posedge clk_i);
    req_a <= 8'h0;
    req_b <= 8'h0;
    for (k = 0; k < 300 && (la.gnt_n !== 1'b1 || lb.gnt_n !== 1'b1); k++) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
  endtask : wait_grant
  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    seed = 32'h44e90931;
    {rst_i, cyc, stb, we, cyc_ack, sel} = {5'h10, 4'hf};
    {adr, dat, lpc_req, req_a, req_b, seen_ack} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, dma_pkg::PORT_STYLE, 32'h0);
    check(rdv, {16'h0, dma_pkg::STYLE_RESET});
    wb(1'b0, 8'h3f, 32'h0);
    check(rdv, 32'h0);
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      wb(1'b1, dma_pkg::PORT_STYLE, v);
      wb(1'b0, dma_pkg::PORT_STYLE, 32'h0);
      check(rdv, {16'h0, v[15:0] & dma_pkg::STYLE_WMASK});
      // Patterns change between rounds: channels withdrawn and added while masked
      req_a <= v[23:16] | 8'h01;
      req_b <= v[31:24] | 8'h02;
      repeat (40) @(posedge clk_i);
      wb(1'b0, dma_pkg::PORT_PEND_A, 32'h0);
      check(rdv, {24'h0, v[23:16] | 8'h01});
      wb(1'b0, dma_pkg::PORT_PEND_B, 32'h0);
      check(rdv, {24'h0, v[31:24] | 8'h02});
    end
    req_a <= 8'h0;
    req_b <= 8'h0;
    repeat (40) @(posedge clk_i);
    wb(1'b1, dma_pkg::PORT_STYLE, 32'h0804);
    for (i = 0; i < 4; i++) begin
      hi = i[0];
      v = $random(seed);
      wb(1'b1, hi ? dma_pkg::PORT_CLR_PTR1 : dma_pkg::PORT_CLR_PTR0, v);
      wr16(hi ? 8'hc4 : 8'h02, v[15:0]);
      wr16(hi ? 8'hc6 : 8'h03, 16'h0);
      wb(1'b1, dma_pkg::PAGE_PORT[hi ? 5 : 1], {24'h0, v[23:16]});
      wb(1'b1, hi ? dma_pkg::PORT_MODE1 : dma_pkg::PORT_MODE0,
         {26'h0, i[1], i == 3, i[1] ? 4'h9 : 4'h5});
      wb(1'b1, hi ? dma_pkg::PORT_CLR_MASK1 : dma_pkg::PORT_CLR_MASK0, v);
      seen_ack = 8'h0;
      req_a <= hi ? 8'h0 : 8'h02;
      req_b <= hi ? 8'h20 : 8'h0;
      wait_grant();
      check(32'(seen_ack), hi ? 32'h20 : 32'h02);
      check(32'(seen_mem), hi ? {v[23:17], v[15:0], 1'b0} : v[23:0]);
      check(32'(seen_ch), hi ? 32'h5 : 32'h1);
      check(32'(seen_we), i[1] ? 32'h0 : 32'h1);
      check(32'(seen_tc), 32'h1);
      wb(1'b1, hi ? dma_pkg::PORT_CLR_PTR1 : dma_pkg::PORT_CLR_PTR0, 32'h0);
      rd16(hi ? 8'hc4 : 8'h02);
      check(32'(got), 32'(exp_addr(i, v[15:0])));
      rd16(hi ? 8'hc6 : 8'h03);
      check(32'(got), i == 3 ? 32'h0 : 32'hffff);
    end
    wb(1'b1, dma_pkg::PORT_MCLR0, v);
    seen_ack = 8'h0;
    req_a <= 8'h02;
    repeat (60) @(posedge clk_i);
    check(32'(seen_ack), 32'h0);
    wb(1'b1, dma_pkg::PORT_CLR_MASK0, 32'h0);
    wait_grant();
    check(32'(seen_ack), 32'h02);
    // Channel 3 routed to LPC: served without touching either grant line
    seen_ack = 8'h0;
    wb(1'b1, dma_pkg::PORT_STYLE, 32'h0800);
    lpc_req <= 8'h08;
    repeat (40) @(posedge clk_i);
    check(32'(seen_ch), 32'h3);
    check(32'(seen_ack), 32'h0);
    final_report();
  end
endmodule : tb
